/* File: hw/dcil_consts.vh */
// Constants for the drive command input logic
`ifndef DCIL_CONSTS_VH
`define DCIL_CONSTS_VH
// Clock rate
`define DCIL_CLK_HZ 10000000
// Response times
`define DCIL_SLOW_RESP_NS 1000000
`define DCIL_DIR_RESP_NS 100000
// Filter windows, half the response time, rounded down in cycles
`define DCIL_SLOW_FILT_CYC ((`DCIL_SLOW_RESP_NS / 2) / (1000000000 / `DCIL_CLK_HZ))
`define DCIL_DIR_FILT_CYC ((`DCIL_DIR_RESP_NS / 2) / (1000000000 / `DCIL_CLK_HZ))
// APB register offsets
`define DCIL_REG_CTRL 12'h000
`define DCIL_REG_STAT 12'h004
`define DCIL_REG_POS 12'h008
// Control fields
`define DCIL_CTRL_POL_EN 0
`define DCIL_CTRL_POL_CW 1
`define DCIL_CTRL_POL_CCW 2
`define DCIL_CTRL_POL_DIR 3
`define DCIL_CTRL_CW_ON 4
`define DCIL_CTRL_CCW_ON 5
`define DCIL_CTRL_SW_EN 6
`define DCIL_CTRL_NET_EN 7
`define DCIL_CTRL_POS_MODE 8
`define DCIL_CTRL_STEP_SRC 9
`define DCIL_CTRL_HALL_MODE 10
`define DCIL_CTRL_FAULT_SET 11
`define DCIL_CTRL_RESET 32'h0000_0030
// Status fields
`define DCIL_STAT_ENABLED 0
`define DCIL_STAT_FAULT 1
`define DCIL_STAT_CW_BLK 2
`define DCIL_STAT_CCW_BLK 3
`define DCIL_STAT_DIR 4
`define DCIL_STAT_HALL 5
`endif

/* File: hw/dcil_top.v */
// Drive command input logic: conditioning, polarity, enable, limits, step/dir, feedback select
`timescale 1ns/1ps
`include "dcil_consts.vh"

// Notes on behaviour
// - Input is active while its isolator diode conducts; open circuit is inactive.
// - Each input has a stored polarity deciding whether active asserts its function; the code stores none for the step input.
// - Normal polarity: active enable input allows enabling, open circuit disables.
// - Deasserted enable function always disables the drive, whatever else is set.
// - Enabling completes only with no fault, software enable and network enable.
// - Inactive enable function clears all latched drive faults.
// - Asserted clockwise inhibit blocks clockwise motion only.
// - Clockwise inhibit has an on/off setting; off ignores the input.
// - Counter-clockwise inhibit mirrors clockwise with own setting and polarity.
// - Step/dir position mode: direction input without current means positive, clockwise.
// - Enable and inhibits act within 1 ms, direction within 100 us.
// - Feedback port runs serial device mode or Hall mode as attached.
// - Hall mode reads pulled-up phases U, V, W; serial negative line unused.
// - A step counts on diode current falling to none; rising does nothing.
// - Run output on only while powered, not faulted and enabled.
module dcil_top #(
  parameter SLOW_FILT = `DCIL_SLOW_FILT_CYC,
  parameter DIR_FILT = `DCIL_DIR_FILT_CYC,
  parameter POS_W = 32
) (
  input wire sys_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire drive_enable_input,
  input wire cw_limit_input,
  input wire ccw_limit_input,
  input wire step_direction_input,
  input wire fast_step_input,
  input wire power_good,
  input wire fault_event,
  input wire feedback_com_pos,
  input wire hall_phase_u,
  input wire hall_phase_v,
  input wire hall_phase_w,
  output reg drive_enabled,
  output reg cw_motion_block,
  output reg ccw_motion_block,
  output reg step_pulse,
  output reg step_dir_positive,
  output reg [2:0] hall_state,
  output reg serial_rx,
  output reg fault_indicator_output,
  output reg run_indicator_output
);

  // ******************************
  // Reset release
  // ******************************
  reg rst_s1_q;
  reg rst_n_q;

  // Two-stage reset release
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ******************************
  // Input synchronisers
  // ******************************
  // Bit order: 0 enable, 1 cw, 2 ccw, 3 dir, 4 step, 5 com+/U, 6 V, 7 W
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  wire [7:0] raw_in;
  assign raw_in = {hall_phase_w, hall_phase_v, feedback_com_pos, fast_step_input,
                   step_direction_input, ccw_limit_input, cw_limit_input, drive_enable_input};

  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ******************************
  // Registers
  // ******************************
  reg [31:0] ctrl_q;
  reg [POS_W-1:0] pos_q;
  reg fault_q;
  wire [31:0] stat_w;

  // APB slave, zero wait states
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `DCIL_CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      // Write lands at the access edge, where the master sees ready
      if (psel && penable && pready && pwrite && (paddr == `DCIL_REG_CTRL))
        ctrl_q <= {20'h0_0000, pwdata[11:0]};
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `DCIL_REG_CTRL: begin
            if (!pwrite)
              prdata <= ctrl_q;
          end
          `DCIL_REG_STAT: begin
            if (!pwrite)
              prdata <= stat_w;
          end
          `DCIL_REG_POS: begin
            if (!pwrite)
              prdata <= pos_q;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ******************************
  // Input filters and polarity
  // ******************************
  // Filter counter width from the slow window
  function integer clog2f;
    input integer v;
    integer i;
    begin
      clog2f = 1;
      for (i = 0; (1 << i) < v; i = i + 1)
        clog2f = i + 1;
    end
  endfunction

  localparam CW_ = clog2f(SLOW_FILT + 1);

  // active means diode current; polarity flips the function
  function func_level;
    input phys;
    input invert;
    begin
      func_level = phys ^ invert;
    end
  endfunction

  reg [3:0] filt_q;
  reg [CW_-1:0] cnt0_q, cnt1_q, cnt2_q, cnt3_q;

  // debounce: a level must stay steady half the response time
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      filt_q <= 4'h0;
      cnt0_q <= {CW_{1'b0}};
      cnt1_q <= {CW_{1'b0}};
      cnt2_q <= {CW_{1'b0}};
      cnt3_q <= {CW_{1'b0}};
    end else begin
      if (sync2_q[0] == filt_q[0])
        cnt0_q <= {CW_{1'b0}};
      else if (cnt0_q >= SLOW_FILT[CW_-1:0]) begin
        filt_q[0] <= sync2_q[0];
        cnt0_q <= {CW_{1'b0}};
      end else
        cnt0_q <= cnt0_q + 1'b1;
      if (sync2_q[1] == filt_q[1])
        cnt1_q <= {CW_{1'b0}};
      else if (cnt1_q >= SLOW_FILT[CW_-1:0]) begin
        filt_q[1] <= sync2_q[1];
        cnt1_q <= {CW_{1'b0}};
      end else
        cnt1_q <= cnt1_q + 1'b1;
      if (sync2_q[2] == filt_q[2])
        cnt2_q <= {CW_{1'b0}};
      else if (cnt2_q >= SLOW_FILT[CW_-1:0]) begin
        filt_q[2] <= sync2_q[2];
        cnt2_q <= {CW_{1'b0}};
      end else
        cnt2_q <= cnt2_q + 1'b1;
      if (sync2_q[3] == filt_q[3])
        cnt3_q <= {CW_{1'b0}};
      else if (cnt3_q >= DIR_FILT[CW_-1:0]) begin
        filt_q[3] <= sync2_q[3];
        cnt3_q <= {CW_{1'b0}};
      end else
        cnt3_q <= cnt3_q + 1'b1;
    end
  end

  wire en_func;
  wire cw_func;
  wire ccw_func;
  wire dir_func;
  assign en_func = func_level(filt_q[0], ctrl_q[`DCIL_CTRL_POL_EN]);
  // function switch gates the cw inhibit
  assign cw_func = func_level(filt_q[1], ctrl_q[`DCIL_CTRL_POL_CW]) & ctrl_q[`DCIL_CTRL_CW_ON];
  assign ccw_func = func_level(filt_q[2], ctrl_q[`DCIL_CTRL_POL_CCW]) &
                    ctrl_q[`DCIL_CTRL_CCW_ON];
  assign dir_func = ~func_level(filt_q[3], ctrl_q[`DCIL_CTRL_POL_DIR]);

  // ******************************
  // Enable and faults
  // ******************************
  wire enable_ok;
  // all enable sources and no fault
  assign enable_ok = en_func & ctrl_q[`DCIL_CTRL_SW_EN] & ctrl_q[`DCIL_CTRL_NET_EN] &
                     ~fault_q & power_good;

  // Fault latch and enable state
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_q <= 1'b0;
      drive_enabled <= 1'b0;
    end else begin
      // inactive enable clears faults; new fault wins
      if (fault_event || ctrl_q[`DCIL_CTRL_FAULT_SET])
        fault_q <= 1'b1;
      else if (!en_func)
        fault_q <= 1'b0;
      drive_enabled <= enable_ok & ~fault_event;
    end
  end

  // ******************************
  // Limits, step and direction
  // ******************************
  reg step_prev_q;
  wire step_mode;
  wire step_fall;
  wire dir_blocked;
  assign step_mode = ctrl_q[`DCIL_CTRL_POS_MODE] & ctrl_q[`DCIL_CTRL_STEP_SRC];
  // count on current to no current
  assign step_fall = step_prev_q & ~sync2_q[4];
  assign dir_blocked = dir_func ? cw_func : ccw_func;

  // Step counting and motion gating
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step_prev_q <= 1'b0;
      pos_q <= {POS_W{1'b0}};
      step_pulse <= 1'b0;
      step_dir_positive <= 1'b1;
      cw_motion_block <= 1'b0;
      ccw_motion_block <= 1'b0;
    end else begin
      step_prev_q <= sync2_q[4];
      // each inhibit blocks its own direction only, enable untouched
      cw_motion_block <= cw_func;
      ccw_motion_block <= ccw_func;
      step_dir_positive <= dir_func;
      step_pulse <= 1'b0;
      if (step_mode && drive_enabled && step_fall && !dir_blocked) begin
        step_pulse <= 1'b1;
        if (dir_func)
          pos_q <= pos_q + 1'b1;
        else
          pos_q <= pos_q - 1'b1;
      end
    end
  end

  // ******************************
  // Feedback port and indicators
  // ******************************
  // Hall or serial mode on shared pins
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hall_state <= 3'b111;
      serial_rx <= 1'b1;
      fault_indicator_output <= 1'b0;
      run_indicator_output <= 1'b0;
    end else begin
      if (ctrl_q[`DCIL_CTRL_HALL_MODE]) begin
        hall_state <= sync2_q[7:5];
        serial_rx <= 1'b1;
      end else begin
        hall_state <= 3'b111;
        serial_rx <= sync2_q[5];
      end
      fault_indicator_output <= power_good & ~fault_q;
      // run only when powered, healthy, enabled
      run_indicator_output <= power_good & ~fault_q & drive_enabled;
    end
  end

  assign stat_w = {26'h000_0000, ctrl_q[`DCIL_CTRL_HALL_MODE], step_dir_positive,
                   ccw_motion_block, cw_motion_block, fault_q, drive_enabled};

endmodule

/* File: testbench/dcil_monitor.sv */
// Port checker for the drive command input logic
`timescale 1ns/1ps
module dcil_monitor (
  input wire sys_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire fast_step_input,
  input wire power_good,
  input wire drive_enabled,
  input wire step_pulse,
  input wire [2:0] hall_state,
  input wire serial_rx,
  input wire fault_indicator_output,
  input wire run_indicator_output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Pin fell three cycles before the pulse
  sequence pin_fall_s;
    $past(fast_step_input, 4) && !$past(fast_step_input, 3);
  endsequence
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  step_edge_a: assert property (step_pulse |-> pin_fall_s)
    else $error("step without falling pin");
  step_single_a: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse too long");
  step_enabled_a: assert property (step_pulse |-> drive_enabled || $past(drive_enabled))
    else $error("step while disabled");
  run_needs_a: assert property (run_indicator_output |-> fault_indicator_output)
    else $error("run while faulted");
  run_drop_a: assert property ($fell(drive_enabled) |-> ##[0:1] !run_indicator_output)
    else $error("run stays after disable");
  power_off_a: assert property (!power_good |-> ##[0:4] !fault_indicator_output)
    else $error("indicator on without power");
  hall_idle_a: assert property (!serial_rx |-> hall_state == 3'b111)
    else $error("hall state in serial mode");
endmodule
bind dcil_top dcil_monitor u_dcil_monitor (.*);

/* File: testbench/dcil_field_model.sv */
// Field side: command source, limit switches, Hall sensor
`timescale 1ns/1ps
module dcil_field_model #(
  // Direction setup in clocks: 100 us at the 100 ns bench clock
  parameter SETUP = 1000
) (
  input wire sys_clk,
  output reg drive_enable_input,
  output reg cw_limit_input,
  output reg ccw_limit_input,
  output reg step_direction_input,
  output reg fast_step_input,
  output wire feedback_com_pos,
  output wire hall_phase_u,
  output wire hall_phase_v,
  output wire hall_phase_w
);
  reg [2:0] sens_on;
  // open collector phases pulled high when off
  assign {hall_phase_w, hall_phase_v, hall_phase_u} = ~sens_on;
  assign feedback_com_pos = hall_phase_u;
  // high means diode current, all open at start
  initial begin
    {drive_enable_input, cw_limit_input, ccw_limit_input} = 3'b000;
    {step_direction_input, fast_step_input, sens_on} = 5'b0_0000;
  end
  // Set field levels
  task lvl(input e, input c, input cc, input [2:0] h);
    @(posedge sys_clk);
    {drive_enable_input, cw_limit_input, ccw_limit_input} <= {e, c, cc};
    sens_on <= h;
  endtask
  // direction settles before and holds after a wide pulse
  task step(input dir);
    @(posedge sys_clk);
    step_direction_input <= dir;
    repeat (SETUP) @(posedge sys_clk);
    fast_step_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    fast_step_input <= 1'b0;
    repeat (SETUP) @(posedge sys_clk);
  endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the drive command input logic
`timescale 1ns/1ps
`include "dcil_consts.vh"
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  reg sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg power_good = 0, fault_event = 0, err;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, drive_enable_input, cw_limit_input, ccw_limit_input;
  wire step_direction_input, fast_step_input, feedback_com_pos;
  wire hall_phase_u, hall_phase_v, hall_phase_w, drive_enabled, cw_motion_block;
  wire ccw_motion_block, step_pulse, step_dir_positive, serial_rx;
  wire fault_indicator_output, run_indicator_output;
  wire [2:0] hall_state;
  integer bad_count = 0, total_checks = 0, exp_pos = 0, i, d;
  integer pulses = 0, exp_pulses = 0;
  // Count step pulses the design reports
  always @(posedge sys_clk)
    if (step_pulse === 1'b1)
      pulses <= pulses + 1;
  always #50 sys_clk = ~sys_clk;
  dcil_top #(.SLOW_FILT(4), .DIR_FILT(2)) u_dcil_top (.*);
  dcil_field_model u_dcil_field_model (.*);
  // Verdict and end of run
  task results;
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One APB transfer, waits for ready under a bound
  task apb(input w, input [11:0] a, input [31:0] dat);
    integer k;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    for (k = 0; pready !== 1'b1; k++) begin
      if (k == 20) begin
        bad_count++;
        results;
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task step(input integer dir);
    u_dcil_field_model.step(dir[0]);
  endtask
  task lvl(input e, input c, input cc, input [2:0] h);
    u_dcil_field_model.lvl(e, c, cc, h);
    cyc(20);
  endtask
  // Read back the position and compare with the model
  task pos_chk;
    apb(0, `DCIL_REG_POS, 0);
    `CK("pos", exp_pos, rd)
    `CK("pulses", exp_pulses, pulses)
  endtask
  initial begin
    cyc(100000);
    bad_count++;
    results;
  end
  // Main sequence
  initial begin
    d = $urandom(32'h5c85);
    cyc(8);
    resetn <= 1;
    power_good <= 1;
    cyc(3);
    apb(0, `DCIL_REG_CTRL, 0);
    `CK("ctrl_rst", 32'h0000_0030, rd)
    `CK("hall_idle", 3'b111, hall_state)
    lvl(0, 0, 0, 3'b001);
    `CK("serial", 4'b0111, {serial_rx, hall_state})
    apb(0, 12'h0ff, 0);
    `CK("bad_addr", 1'b1, err)
    apb(1, `DCIL_REG_CTRL, 32'h0000_03f0);
    lvl(1, 0, 0, 0);
    `CK("enabled", 1'b1, drive_enabled)
    `CK("run", 1'b1, run_indicator_output)
    for (i = 0; i < 6; i++) begin
      d = $urandom % 2;
      step(d);
      exp_pos += d ? -1 : 1;
      exp_pulses++;
      `CK("dir", !d, step_dir_positive)
    end
    pos_chk;
    lvl(1, 1, 0, 0);
    `CK("cw_blk", 2'b10, {cw_motion_block, ccw_motion_block})
    step(0);
    step(1);
    exp_pos -= 1;
    exp_pulses++;
    pos_chk;
    lvl(1, 1, 1, 0);
    `CK("both_blk", 3'b111, {cw_motion_block, ccw_motion_block, drive_enabled})
    apb(0, `DCIL_REG_STAT, 0);
    `CK("stat", 32'h0000_000d, rd)
    step(1);
    pos_chk;
    apb(1, `DCIL_REG_CTRL, 32'h0000_03e0);
    cyc(5);
    `CK("cw_off", 1'b0, cw_motion_block)
    fault_event <= 1;
    cyc(2);
    fault_event <= 0;
    cyc(5);
    `CK("fault", 3'b000, {drive_enabled, fault_indicator_output, run_indicator_output})
    lvl(0, 1, 1, 0);
    `CK("cleared", 2'b01, {drive_enabled, fault_indicator_output})
    lvl(1, 0, 0, 0);
    `CK("reenable", 1'b1, drive_enabled)
    apb(1, `DCIL_REG_CTRL, 32'h0000_03f1);
    cyc(5);
    `CK("pol_off", 1'b0, drive_enabled)
    lvl(0, 0, 0, 0);
    `CK("pol_on", 1'b1, drive_enabled)
    apb(1, `DCIL_REG_CTRL, 32'h0000_0400);
    for (i = 0; i < 3; i++) begin
      d = $urandom % 8;
      lvl(0, 0, 0, d[2:0]);
      `CK("hall", {1'b1, ~d[2:0]}, {serial_rx, hall_state})
    end
    power_good <= 0;
    cyc(5);
    `CK("unpowered", 1'b0, fault_indicator_output)
    results;
  end
endmodule
